// ### hdl/lps_sequencer.sv
// power key sequencer, sleep mode control and apb registers
//
// Summary of operation
// [R01] while the key is high the always-on domain stays powered
// [R02] with key high, regulators turn on by themselves in fixed order
// [R03] crystal and io regulators first, switching converter after interval
// [R04] software may reprogram intervals; later sequences use new values
// [R05] outside party raises the key about five supply rise times late
// [R06] wait for the internal rc oscillator before sequencing starts
// [R07] software switches each regulator on and off through registers
// [R08] io regulator only enabled when the io supply option is 1.8 V
// [R09] key low means deepest sleep with everything unpowered
// [R10] software register write enters the intermediate sleep mode
// [R11] key low during intermediate sleep drops to deepest sleep
// [R12] sleep ends when the counter reaches the programmed compare value
// [R13] sleep also ends on a qualified wake pin event
// [R14] retention sleep like intermediate sleep but retention memory powered
// [R15] data sram power is removed during sleep
// [R16] black-out clears all state like a reset; brown-out only flagged
// [R17] wake edge selectable, new level must hold 200 us
// [R18] 36-bit free-running counter advancing per slow clock tick
// [R19] main domain held in reset until converter and core ldo settle
`timescale 1ns/1ps
`default_nettype none
module lps_sequencer #(
  parameter int unsigned RC_WAIT_CYC = lps_pkg::RC_OSC_STARTUP_CYC,
  parameter int unsigned WAKE_HOLD_CYC = lps_pkg::WAKE_HOLD_CYC
) (
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic POWER_KEY_PIN_IN,
  input wire logic WAKE_PIN_IN,
  input wire logic RTC_TICK_IN,
  input wire logic IO_SUPPLY_1V8_IN,
  input wire logic BLACKOUT_IN,
  input wire logic BROWNOUT_IN,
  output logic RTC_DOMAIN_EN_OUT,
  output logic LDO_XTAL_EN_OUT,
  output logic LDO_DIO_EN_OUT,
  output logic DCDC_EN_OUT,
  output logic LDO_DIG_EN_OUT,
  output logic SRAM_PWR_EN_OUT,
  output logic RET_PWR_EN_OUT,
  output logic MAIN_RST_N_OUT,
  output logic IRQ_OUT
);
  typedef enum logic [2:0] {
    S_OFF, S_RCWAIT, S_WDCDC, S_WDLDO, S_WRST, S_ACTIVE, S_SLEEP
  } lps_state_t;

  typedef struct packed {
    lps_state_t state;
    logic [15:0] cnt;
    logic [35:0] rtc;
    logic [35:0] cmp;
    logic [15:0] int_dcdc;
    logic [15:0] int_dldo;
    logic [15:0] int_rst;
    logic [3:0] reg_en;
    logic ret_mode;
    logic edge_rise;
    logic [3:0] status;
    logic [3:0] mask;
    logic tick_d;
    logic aon;
    logic xtal;
    logic dio;
    logic dcdc;
    logic dig;
    logic sram;
    logic ret;
    logic main_rst_n;
    logic [31:0] prdata;
    logic pslverr;
  } lps_regs_t;

  localparam lps_regs_t ST_RST = '{
    state: S_OFF, cnt: 16'h0000, rtc: 36'h0, cmp: 36'h0,
    int_dcdc: lps_pkg::DCDC_INTERVAL_CYC,
    int_dldo: lps_pkg::DLDO_INTERVAL_CYC,
    int_rst: lps_pkg::RST_INTERVAL_CYC,
    reg_en: lps_pkg::REG_EN_RST, ret_mode: 1'b0,
    edge_rise: lps_pkg::EDGE_RISE_RST, status: 4'h0,
    mask: lps_pkg::MASK_RST, tick_d: 1'b0, aon: 1'b0, xtal: 1'b0,
    dio: 1'b0, dcdc: 1'b0, dig: 1'b0, sram: 1'b0, ret: 1'b0,
    main_rst_n: 1'b0, prdata: 32'h0, pslverr: 1'b0
  };

  lps_regs_t st_reg;
  lps_regs_t st_next;
  logic [5:0] pins_s;
  logic key_s;
  logic wake_s;
  logic tick_s;
  logic io1v8_s;
  logic blackout_s;
  logic brownout_s;
  logic wake_evt;
  logic tick;
  logic wr;
  logic wr_go;
  logic [3:0] set_v;
  logic [3:0] clr_v;
  logic [31:0] rdata;

  // every pin crosses into the clock domain before logic looks at it
  lps_sync #(
    .WIDTH(6)
  ) u_sync (
    .clk_in(CLK_IN),
    .rst_n_in(RESET_N_IN),
    .d_in({BROWNOUT_IN, BLACKOUT_IN, IO_SUPPLY_1V8_IN, RTC_TICK_IN,
      WAKE_PIN_IN, POWER_KEY_PIN_IN}),
    .q_out(pins_s)
  );
  assign key_s = pins_s[0];
  assign wake_s = pins_s[1];
  assign tick_s = pins_s[2];
  assign io1v8_s = pins_s[3];
  assign blackout_s = pins_s[4];
  assign brownout_s = pins_s[5];

  lps_wake_det #(
    .HOLD_CYC(WAKE_HOLD_CYC)
  ) u_wake (
    .clk_in(CLK_IN),
    .rst_n_in(RESET_N_IN),
    .arm_in(st_reg.state == S_SLEEP),
    .level_in(wake_s),
    .rising_in(st_reg.edge_rise),
    .wake_out(wake_evt)
  );

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= lps_pkg::OFS_STATE);
  endfunction

  // interval elapsed; a zero interval behaves as one cycle
  function automatic logic done(input logic [15:0] c, input logic [15:0] l);
    done = ({1'b0, c} + 17'h00001) >= {1'b0, l};
  endfunction

  assign tick = tick_s & ~st_reg.tick_d;
  assign wr = PSEL_IN && PENABLE_IN && PWRITE_IN && mapped(PADDR_IN);
  assign wr_go = wr && PADDR_IN == lps_pkg::OFS_CTRL &&
    PWDATA_IN[lps_pkg::CTRL_GO_BIT];

  always_comb begin
    case (PADDR_IN)
      lps_pkg::OFS_CTRL: rdata = {29'h0, st_reg.edge_rise,
        st_reg.ret_mode, 1'b0};
      lps_pkg::OFS_REG_EN: rdata = {28'h0, st_reg.reg_en};
      lps_pkg::OFS_INT_DCDC: rdata = {16'h0, st_reg.int_dcdc};
      lps_pkg::OFS_INT_DLDO: rdata = {16'h0, st_reg.int_dldo};
      lps_pkg::OFS_INT_RST: rdata = {16'h0, st_reg.int_rst};
      lps_pkg::OFS_CNT_LO: rdata = st_reg.rtc[31:0]; // [R18]
      lps_pkg::OFS_CNT_HI: rdata = {28'h0, st_reg.rtc[35:32]};
      lps_pkg::OFS_CMP_LO: rdata = st_reg.cmp[31:0];
      lps_pkg::OFS_CMP_HI: rdata = {28'h0, st_reg.cmp[35:32]};
      lps_pkg::OFS_STATUS: rdata = {28'h0, st_reg.status};
      lps_pkg::OFS_MASK: rdata = {28'h0, st_reg.mask};
      lps_pkg::OFS_STATE: rdata = {23'h0, io1v8_s, st_reg.main_rst_n,
        st_reg.ret, st_reg.sram, st_reg.dig, st_reg.dcdc,
        st_reg.dio, st_reg.xtal, 1'b0};
      default: rdata = 32'h0;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    set_v = 4'h0;
    clr_v = 4'h0;
    st_next.tick_d = tick_s;
    st_next.aon = 1'b1; // [R01]
    if (tick) begin
      st_next.rtc = st_reg.rtc + 36'h1; // [R18]
    end
    // read data is latched in the setup phase, so the answer is ready
    // in the first access cycle with no wait states
    if (PSEL_IN && !PENABLE_IN) begin
      st_next.prdata = rdata;
      st_next.pslverr = !mapped(PADDR_IN);
    end
    if (wr) begin
      case (PADDR_IN)
        lps_pkg::OFS_CTRL: begin
          st_next.ret_mode = PWDATA_IN[lps_pkg::CTRL_RET_BIT];
          st_next.edge_rise = PWDATA_IN[lps_pkg::CTRL_EDGE_BIT]; // [R17]
        end
        lps_pkg::OFS_REG_EN: st_next.reg_en = PWDATA_IN[3:0]; // [R07]
        lps_pkg::OFS_INT_DCDC: st_next.int_dcdc = PWDATA_IN[15:0]; // [R04]
        lps_pkg::OFS_INT_DLDO: st_next.int_dldo = PWDATA_IN[15:0]; // [R04]
        lps_pkg::OFS_INT_RST: st_next.int_rst = PWDATA_IN[15:0]; // [R04]
        lps_pkg::OFS_CMP_LO: st_next.cmp[31:0] = PWDATA_IN;
        lps_pkg::OFS_CMP_HI: st_next.cmp[35:32] = PWDATA_IN[3:0];
        lps_pkg::OFS_STATUS: clr_v = PWDATA_IN[3:0];
        lps_pkg::OFS_MASK: st_next.mask = PWDATA_IN[3:0];
        default: st_next.mask = st_reg.mask;
      endcase
    end
    set_v[lps_pkg::ST_BROWN_BIT] = brownout_s; // [R16]
    case (st_reg.state)
      S_OFF: begin
        st_next.state = S_RCWAIT; // [R02]
        st_next.cnt = 16'h0000;
      end
      S_RCWAIT: begin
        if (done(st_reg.cnt, 16'(RC_WAIT_CYC))) begin // [R06]
          st_next.xtal = 1'b1; // [R03]
          st_next.dio = io1v8_s; // [R08]
          st_next.state = S_WDCDC;
          st_next.cnt = 16'h0000;
        end else begin
          st_next.cnt = st_reg.cnt + 16'h0001;
        end
      end
      S_WDCDC: begin
        if (done(st_reg.cnt, st_reg.int_dcdc)) begin // [R04]
          st_next.dcdc = 1'b1; // [R03]
          st_next.state = S_WDLDO;
          st_next.cnt = 16'h0000;
        end else begin
          st_next.cnt = st_reg.cnt + 16'h0001;
        end
      end
      S_WDLDO: begin
        if (done(st_reg.cnt, st_reg.int_dldo)) begin // [R04]
          st_next.dig = 1'b1; // [R02]
          st_next.state = S_WRST;
          st_next.cnt = 16'h0000;
        end else begin
          st_next.cnt = st_reg.cnt + 16'h0001;
        end
      end
      S_WRST: begin
        if (done(st_reg.cnt, st_reg.int_rst)) begin
          st_next.main_rst_n = 1'b1; // [R19]
          st_next.sram = 1'b1;
          st_next.ret = 1'b1;
          st_next.state = S_ACTIVE;
          set_v[lps_pkg::ST_UP_BIT] = 1'b1;
        end else begin
          st_next.cnt = st_reg.cnt + 16'h0001;
        end
      end
      S_ACTIVE: begin
        st_next.xtal = st_reg.reg_en[lps_pkg::EN_XTAL_BIT]; // [R07]
        st_next.dio = st_reg.reg_en[lps_pkg::EN_DIO_BIT] & io1v8_s; // [R08]
        st_next.dcdc = st_reg.reg_en[lps_pkg::EN_DCDC_BIT]; // [R07]
        st_next.dig = st_reg.reg_en[lps_pkg::EN_DIG_BIT];
        // dropping the converter or core ldo puts the core back in reset
        st_next.main_rst_n = st_next.dcdc & st_next.dig; // [R19]
        if (wr_go) begin
          st_next.state = S_SLEEP; // [R10]
          st_next.xtal = 1'b0;
          st_next.dio = 1'b0;
          st_next.dcdc = 1'b0;
          st_next.dig = 1'b0;
          st_next.main_rst_n = 1'b0;
          st_next.sram = 1'b0; // [R15]
          st_next.ret = PWDATA_IN[lps_pkg::CTRL_RET_BIT]; // [R14]
        end
      end
      S_SLEEP: begin
        if (st_reg.rtc == st_reg.cmp || wake_evt) begin
          set_v[lps_pkg::ST_TIMER_BIT] = st_reg.rtc == st_reg.cmp; // [R12]
          set_v[lps_pkg::ST_PIN_BIT] = wake_evt; // [R13]
          // the rc oscillator is still running, so its wait is skipped
          st_next.state = S_WDCDC;
          st_next.cnt = 16'h0000;
          st_next.xtal = 1'b1;
          st_next.dio = io1v8_s; // [R08]
          st_next.ret = 1'b1; // [R14]
        end
      end
      default: st_next.state = S_OFF;
    endcase
    // a clear in the same cycle as an event never loses the event
    st_next.status = (st_reg.status & ~clr_v) | set_v;
    if (!key_s || blackout_s) begin
      st_next = ST_RST; // [R09] [R11] [R16]
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign PREADY_OUT = 1'b1;
  assign PRDATA_OUT = st_reg.prdata;
  assign PSLVERR_OUT = st_reg.pslverr;
  assign RTC_DOMAIN_EN_OUT = st_reg.aon;
  assign LDO_XTAL_EN_OUT = st_reg.xtal;
  assign LDO_DIO_EN_OUT = st_reg.dio;
  assign DCDC_EN_OUT = st_reg.dcdc;
  assign LDO_DIG_EN_OUT = st_reg.dig;
  assign SRAM_PWR_EN_OUT = st_reg.sram;
  assign RET_PWR_EN_OUT = st_reg.ret;
  assign MAIN_RST_N_OUT = st_reg.main_rst_n;
  assign IRQ_OUT = |(st_reg.status & st_reg.mask);

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  sequence s_alive;
    key_s && !blackout_s;
  endsequence
  sequence s_go;
    st_reg.state == S_ACTIVE && wr_go;
  endsequence
  sequence s_timer_hit;
    st_reg.state == S_SLEEP && st_reg.rtc == st_reg.cmp;
  endsequence

  chk_key_low_off: assert property ( // [R09]
    !key_s |=> st_reg.state == S_OFF && !st_reg.xtal && !st_reg.dcdc &&
      !st_reg.dig && !st_reg.ret && !st_reg.aon)
    else $error("key low did not power everything down");
  chk_blackout_clear: assert property ( // [R16]
    blackout_s |=> st_reg.state == S_OFF && st_reg.status == 4'h0 &&
      st_reg.rtc == 36'h0)
    else $error("black-out did not clear state");
  chk_aon_held: assert property ( // [R01]
    s_alive |=> st_reg.aon)
    else $error("always-on domain dropped with key high");
  chk_rc_wait_first: assert property ( // [R06]
    st_reg.state == S_RCWAIT |-> !st_reg.xtal &&
      st_reg.cnt < 16'(RC_WAIT_CYC))
    else $error("regulator enabled before rc oscillator wait");
  chk_dcdc_order: assert property ( // [R03]
    $rose(st_reg.dcdc) && st_reg.state == S_WDLDO |->
      st_reg.xtal && $past(st_reg.state) == S_WDCDC)
    else $error("converter enabled out of order");
  chk_dio_option: assert property ( // [R08]
    $rose(st_reg.dio) |-> $past(io1v8_s))
    else $error("io regulator enabled without 1.8 V option");
  chk_main_rst_hold: assert property ( // [R19]
    st_reg.main_rst_n |-> st_reg.dcdc && st_reg.dig)
    else $error("main reset released without supplies");
  chk_sw_reg_ctrl: assert property ( // [R07]
    s_alive ##0 st_reg.state == S_ACTIVE && !wr_go |=>
      st_reg.dcdc == $past(st_reg.reg_en[lps_pkg::EN_DCDC_BIT]))
    else $error("converter does not follow its enable bit");
  chk_sleep_entry: assert property ( // [R10]
    s_go ##0 s_alive |=> st_reg.state == S_SLEEP && !st_reg.main_rst_n)
    else $error("sleep not entered after request");
  chk_sleep_power: assert property ( // [R14]
    st_reg.state == S_SLEEP |-> st_reg.ret == st_reg.ret_mode &&
      !st_reg.sram && !st_reg.dcdc)
    else $error("sleep power state wrong");
  chk_timer_wake: assert property ( // [R12]
    s_timer_hit ##0 s_alive |=> st_reg.state == S_WDCDC &&
      st_reg.status[lps_pkg::ST_TIMER_BIT])
    else $error("counter match did not wake");
  chk_pin_wake: assert property ( // [R13]
    wake_evt && st_reg.state == S_SLEEP ##0 s_alive |=>
      st_reg.state == S_WDCDC && st_reg.status[lps_pkg::ST_PIN_BIT])
    else $error("wake pin event did not wake");
  chk_rtc_tick: assert property ( // [R18]
    tick ##0 s_alive |=> st_reg.rtc == $past(st_reg.rtc) + 36'h1)
    else $error("counter did not advance on tick");
endmodule
`default_nettype wire

// ### include/lps_pkg.sv
// constants shared by the low power sleep sequencer design files
package lps_pkg;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned RC_OSC_STARTUP_US = 217;
  localparam int unsigned RC_OSC_STARTUP_CYC =
    (RC_OSC_STARTUP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WAKE_HOLD_US = 200;
  localparam int unsigned WAKE_HOLD_CYC =
    (WAKE_HOLD_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned DCDC_INTERVAL_NS = 10000;
  localparam int unsigned DLDO_INTERVAL_NS = 10000;
  localparam int unsigned RST_INTERVAL_NS = 10000;
  localparam logic [15:0] DCDC_INTERVAL_CYC =
    16'((DCDC_INTERVAL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [15:0] DLDO_INTERVAL_CYC =
    16'((DLDO_INTERVAL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [15:0] RST_INTERVAL_CYC =
    16'((RST_INTERVAL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_REG_EN = 8'h04;
  localparam logic [7:0] OFS_INT_DCDC = 8'h08;
  localparam logic [7:0] OFS_INT_DLDO = 8'h0C;
  localparam logic [7:0] OFS_INT_RST = 8'h10;
  localparam logic [7:0] OFS_CNT_LO = 8'h14;
  localparam logic [7:0] OFS_CNT_HI = 8'h18;
  localparam logic [7:0] OFS_CMP_LO = 8'h1C;
  localparam logic [7:0] OFS_CMP_HI = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_MASK = 8'h28;
  localparam logic [7:0] OFS_STATE = 8'h2C;
  localparam int unsigned CTRL_GO_BIT = 0;
  localparam int unsigned CTRL_RET_BIT = 1;
  localparam int unsigned CTRL_EDGE_BIT = 2;
  localparam int unsigned EN_XTAL_BIT = 0;
  localparam int unsigned EN_DIO_BIT = 1;
  localparam int unsigned EN_DCDC_BIT = 2;
  localparam int unsigned EN_DIG_BIT = 3;
  localparam int unsigned ST_TIMER_BIT = 0;
  localparam int unsigned ST_PIN_BIT = 1;
  localparam int unsigned ST_BROWN_BIT = 2;
  localparam int unsigned ST_UP_BIT = 3;
  localparam logic [3:0] REG_EN_RST = 4'hF;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic EDGE_RISE_RST = 1'b1;
endpackage

// ### hdl/lps_sync.sv
// two flip-flop synchroniser for asynchronous input pins
`timescale 1ns/1ps
`default_nettype none
module lps_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } lps_sync_t;
  lps_sync_t sy_reg;
  lps_sync_t sy_next;

  always_comb begin
    sy_next.meta = d_in;
    sy_next.sync = sy_reg.meta;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sy_reg <= '0;
    end else begin
      sy_reg <= sy_next;
    end
  end

  assign q_out = sy_reg.sync;
endmodule
`default_nettype wire

// ### hdl/lps_wake_det.sv
// wake pin edge detector with minimum hold qualification
`timescale 1ns/1ps
`default_nettype none
module lps_wake_det #(
  parameter int unsigned HOLD_CYC = 40000
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic arm_in,
  input wire logic level_in,
  input wire logic rising_in,
  output logic wake_out
);
  localparam int unsigned CW = $clog2(HOLD_CYC + 1);
  typedef struct packed {
    logic prev;
    logic busy;
    logic [CW-1:0] cnt;
    logic evt;
  } lps_wdet_t;
  lps_wdet_t wd_reg;
  lps_wdet_t wd_next;

  // a transition only counts once the new level has stood the full hold
  always_comb begin
    wd_next = wd_reg;
    wd_next.prev = level_in;
    wd_next.evt = 1'b0;
    if (!arm_in) begin
      wd_next.busy = 1'b0;
      wd_next.cnt = '0;
    end else if (wd_reg.busy) begin
      if (level_in != rising_in) begin
        wd_next.busy = 1'b0; // [R17]
      end else if (wd_reg.cnt == CW'(HOLD_CYC - 1)) begin
        wd_next.busy = 1'b0;
        wd_next.evt = 1'b1; // [R17]
      end else begin
        wd_next.cnt = wd_reg.cnt + CW'(1);
      end
    end else if (level_in == rising_in && wd_reg.prev != rising_in) begin
      wd_next.busy = 1'b1; // [R17]
      wd_next.cnt = '0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wd_reg <= '0;
    end else begin
      wd_reg <= wd_next;
    end
  end

  assign wake_out = wd_reg.evt;
endmodule
`default_nettype wire

// ### verification/lps_key_model.sv
// far side model: controller driving the power key, wake pin and slow clock
`timescale 1ns/1ps
`default_nettype none
module lps_key_model #(
  parameter int unsigned RISE_CYC = 4,
  parameter int unsigned TICK_HALF = 20
) (
  input wire logic clk_in,
  output logic key_out,
  output logic wake_out,
  output logic tick_out
);
  initial begin
    key_out = 1'b0;
    wake_out = 1'b0;
  end
  // slow clock runs free; period shortened so timer waits stay short
  always begin
    tick_out = 1'b0;
    forever begin
      repeat (TICK_HALF) @(posedge clk_in);
      tick_out <= ~tick_out;
    end
  end
  task automatic key_on();
    repeat (5 * RISE_CYC) @(posedge clk_in);
    key_out <= 1'b1;
  endtask
  task automatic key_off();
    @(posedge clk_in);
    key_out <= 1'b0;
  endtask
  task automatic wake_idle(input logic lvl);
    @(posedge clk_in);
    wake_out <= lvl;
  endtask
  // new level held for hold cycles, then back to idle
  task automatic wake_edge(input logic lvl, input int hold);
    @(posedge clk_in);
    wake_out <= lvl;
    repeat (hold) @(posedge clk_in);
    wake_out <= ~lvl;
  endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
// self-checking testbench for the low power sleep sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int RC = 20;
  localparam int HOLD = 8;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic io18 = 1'b0, blk = 1'b0, brn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, rd, c0;
  logic pready, pslverr, irq, key, wake, tick, er;
  logic rtc_en, xtal, dio, dcdc, dig, sram, ret, mrst;
  logic [7:0] outs;
  int error_cnt = 0, n_tests = 0, cyc = 0, n;
  assign outs = {rtc_en, xtal, dio, dcdc, dig, sram, ret, mrst};
  always #2.5 clk = ~clk;
  lps_key_model i_lps_key_model (.clk_in(clk), .key_out(key),
    .wake_out(wake), .tick_out(tick));
  lps_sequencer #(.RC_WAIT_CYC(RC), .WAKE_HOLD_CYC(HOLD)) i_lps_sequencer (
    .CLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .POWER_KEY_PIN_IN(key), .WAKE_PIN_IN(wake), .RTC_TICK_IN(tick),
    .IO_SUPPLY_1V8_IN(io18), .BLACKOUT_IN(blk), .BROWNOUT_IN(brn),
    .RTC_DOMAIN_EN_OUT(rtc_en), .LDO_XTAL_EN_OUT(xtal),
    .LDO_DIO_EN_OUT(dio), .DCDC_EN_OUT(dcdc), .LDO_DIG_EN_OUT(dig),
    .SRAM_PWR_EN_OUT(sram), .RET_PWR_EN_OUT(ret),
    .MAIN_RST_N_OUT(mrst), .IRQ_OUT(irq));
  task automatic close_out();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // read data and error are taken at the edge that completes the access
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wait_bit(input int k, input logic v, input int max);
    n = 0;
    while (outs[k] !== v && n < max) begin
      @(posedge clk);
      n++;
    end
    // a level that never comes ends the run as a failure
    if (outs[k] !== v) begin
      error_cnt++;
      close_out();
    end
  endtask
  task automatic t_power(input logic v18);
    @(posedge clk);
    io18 <= v18;
    i_lps_key_model.key_on();
    wait_bit(6, 1'b1, 200);
    check(n >= RC && n <= RC + 6, 1'b1);
    check(outs[7], 1'b1);
    check(outs[5], v18);
    check(outs[4], 1'b0);
    wait_bit(4, 1'b1, 2100);
    check(n >= 1998 && n <= 2002, 1'b1);
    wait_bit(3, 1'b1, 2100);
    check(n >= 1998 && n <= 2002, 1'b1);
    check(outs[0], 1'b0);
    wait_bit(0, 1'b1, 2100);
    check(n >= 1998 && n <= 2002, 1'b1);
    check(outs[2], 1'b1);
    apb(1'b0, lps_pkg::OFS_STATUS, 32'h0);
    check(rd[3], 1'b1);
  endtask
  task automatic t_key_off();
    i_lps_key_model.key_off();
    repeat (6) @(posedge clk);
    check(outs, 8'h00);
    // with the key low the read data register is held cleared as well
    apb(1'b0, lps_pkg::OFS_REG_EN, 32'h0);
    check(rd, 32'h0);
  endtask
  task automatic t_regs();
    apb(1'b0, lps_pkg::OFS_CTRL, 32'h0);
    check(rd[2:0], 3'h4);
    apb(1'b0, lps_pkg::OFS_MASK, 32'h0);
    check(rd[3:0], lps_pkg::MASK_RST);
    apb(1'b0, 8'h30, 32'h0);
    check({er, rd}, {1'b1, 32'h0});
    apb(1'b1, 8'h05, 32'hF);
    check(er, 1'b1);
    apb(1'b1, lps_pkg::OFS_REG_EN, 32'hE);
    repeat (4) @(posedge clk);
    check(outs[6], 1'b0);
    apb(1'b1, lps_pkg::OFS_REG_EN, 32'hF);
    repeat (4) @(posedge clk);
    check(outs[6], 1'b1);
    apb(1'b1, lps_pkg::OFS_INT_DCDC, 32'd30);
    apb(1'b1, lps_pkg::OFS_INT_DLDO, 32'd30);
    apb(1'b1, lps_pkg::OFS_INT_RST, 32'd30);
  endtask
  task automatic t_timer();
    apb(1'b1, lps_pkg::OFS_MASK, 32'h1);
    apb(1'b0, lps_pkg::OFS_CNT_LO, 32'h0);
    c0 = rd;
    repeat (400) @(posedge clk);
    apb(1'b0, lps_pkg::OFS_CNT_LO, 32'h0);
    check(rd - c0 >= 9 && rd - c0 <= 11, 1'b1);
    c0 = rd + 32'd4;
    apb(1'b0, lps_pkg::OFS_CNT_HI, 32'h0);
    apb(1'b1, lps_pkg::OFS_CMP_HI, rd);
    apb(1'b1, lps_pkg::OFS_CMP_LO, c0);
    apb(1'b1, lps_pkg::OFS_CTRL, 32'h5);
    repeat (2) @(posedge clk);
    check(outs, 8'h80);
    wait_bit(6, 1'b1, 400);
    check(n > 40 && n < 400, 1'b1);
    check(irq, 1'b1);
    wait_bit(4, 1'b1, 100);
    check(n >= 28 && n <= 32, 1'b1);
    wait_bit(0, 1'b1, 200);
    apb(1'b0, lps_pkg::OFS_STATUS, 32'h0);
    check(rd[0], 1'b1);
    apb(1'b1, lps_pkg::OFS_STATUS, 32'h1);
    @(posedge clk);
    check(irq, 1'b0);
  endtask
  // e selects the wake edge and also whether retention memory stays on
  task automatic t_pin(input logic e);
    i_lps_key_model.wake_idle(~e);
    apb(1'b1, lps_pkg::OFS_MASK, 32'h2);
    apb(1'b1, lps_pkg::OFS_CTRL, {29'h0, e, e, 1'b1});
    repeat (3) @(posedge clk);
    check({outs[2], outs[1]}, {1'b0, e});
    i_lps_key_model.wake_edge(e, HOLD - 4);
    repeat (20) @(posedge clk);
    check(outs[6], 1'b0);
    i_lps_key_model.wake_edge(e, HOLD + 6);
    wait_bit(6, 1'b1, 60);
    check(n < 60, 1'b1);
    check({outs[1], irq}, 2'h3);
    apb(1'b1, lps_pkg::OFS_STATUS, 32'h2);
    wait_bit(0, 1'b1, 200);
    check(outs[2], 1'b1);
  endtask
  task automatic t_faults();
    apb(1'b1, lps_pkg::OFS_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    t_key_off();
    check(outs[7], 1'b0);
    t_power(1'b1);
    @(posedge clk);
    brn <= 1'b1;
    repeat (4) @(posedge clk);
    brn <= 1'b0;
    apb(1'b0, lps_pkg::OFS_STATUS, 32'h0);
    check({rd[2], irq, outs[0]}, 3'h5);
    @(posedge clk);
    blk <= 1'b1;
    repeat (5) @(posedge clk);
    check(outs, 8'h00);
    blk <= 1'b0;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    check({pready, outs}, 9'h100);
    rst_n <= 1'b1;
    t_power(1'b0);
    t_key_off();
    t_power(1'b1);
    t_regs();
    t_timer();
    t_pin(1'b1);
    t_pin(1'b0);
    t_faults();
    close_out();
  end
endmodule
`default_nettype wire
